// File: bench/llc_model.sv
// Link-side model issuing register reads and writes
`timescale 1ns/10ps
module llc_model (
	input wire logic i_clk, // System clock
	output logic [2:0] o_page_sel, // Page selection
	output logic [3:0] o_port_sel, // Port selection
	output logic [3:0] o_reg_addr, // Register address
	output logic o_reg_rd, // Read strobe
	output logic o_reg_wr, // Write strobe
	output logic [7:0] o_reg_wdata // Write data
);
	logic [7:0] exp_q[$];
	initial begin
		o_page_sel = 3'h0;
		o_port_sel = 4'h0;
		o_reg_addr = 4'h0;
		o_reg_rd = 1'b0;
		o_reg_wr = 1'b0;
		o_reg_wdata = 8'h00;
	end
	// No bus reset here, so child and speed fields are always trusted
	task automatic acc(input logic [2:0] pg, input logic [3:0] pt,
		input logic [3:0] ad, input logic rd, input logic [7:0] d);
		@(posedge i_clk);
		o_page_sel <= pg;
		o_port_sel <= pt;
		o_reg_addr <= ad;
		o_reg_rd <= rd;
		o_reg_wr <= !rd;
		o_reg_wdata <= d;
		if (rd)
			exp_q.push_back(d);
		@(posedge i_clk);
		o_reg_rd <= 1'b0;
		o_reg_wr <= 1'b0;
	endtask
endmodule

// File: bench/phy_pages_sva.sv
// Assertions on the port status and identification register bank
`timescale 1ns/10ps
module phy_pages_sva #(
	parameter int NUM_PORTS = 3
) (
	input wire logic i_clk, // Clock
	input wire logic i_srst, // Reset
	input wire logic [2:0] i_page_sel, // Page
	input wire logic [3:0] i_port_sel, // Port
	input wire logic [3:0] i_reg_addr, // Address
	input wire logic i_reg_rd, // Read strobe
	input wire logic i_reg_wr, // Write strobe
	input wire logic [7:0] i_reg_wdata, // Write data
	input wire logic [7:0] o_reg_rdata, // Read data
	input wire logic o_reg_rvalid, // Read valid
	input wire logic [NUM_PORTS-1:0] i_port_resuming, // Resuming
	input wire logic [NUM_PORTS-1:0] i_port_suspending, // Suspending
	input wire logic [NUM_PORTS-1:0] o_port_disabled, // Disabled
	input wire logic [NUM_PORTS-1:0] o_port_fault_hold, // Fault
	input wire logic o_port_event // Event pulse
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic clr0_q;
	always_ff @(posedge i_clk) begin
		clr0_q <= i_reg_wr && i_page_sel == 3'h0 && i_reg_addr == 4'h9
			&& i_port_sel == 4'h0 && i_reg_wdata[3];
	end
	a_rvalid_after_rd: assert property (
		i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
	a_rvalid_has_cause: assert property (
		$rose(o_reg_rvalid) |-> $past(i_reg_rd)) else $error("stray valid");
	a_rvalid_one_cycle: assert property (
		i_reg_rd ##1 !i_reg_rd |=> !o_reg_rvalid) else $error("long valid");
	a_rdata_holds: assert property (
		!$past(i_reg_rd) && !$past(i_srst) |-> $stable(o_reg_rdata))
		else $error("read data moved");
	a_disable_written: assert property (
		i_reg_wr && i_page_sel == 3'h0 && i_reg_addr == 4'h8
		&& i_port_sel < NUM_PORTS |=> o_port_disabled[$past(i_port_sel)]
		== $past(i_reg_wdata[0])) else $error("disable not written");
	a_disable_by_write: assert property (
		$changed(o_port_disabled) |-> $past(i_reg_wr))
		else $error("disable changed alone");
	a_fault_cause: assert property (
		$rose(o_port_fault_hold[0]) |-> $past(i_port_suspending[0])
		|| $past(i_port_resuming[0])) else $error("fault without cause");
	a_fault_clear_w1: assert property (
		$fell(o_port_fault_hold[0]) |-> clr0_q) else $error("fault lost");
	a_unimpl_port_zero: assert property (
		i_reg_rd && i_page_sel == 3'h0 && i_port_sel >= NUM_PORTS
		|=> o_reg_rdata == 8'h00) else $error("absent port not zero");
	a_compliance_byte: assert property (
		i_reg_rd && i_page_sel == 3'h1 && i_reg_addr == 4'h8
		|=> o_reg_rdata == phy_pages_pkg::COMPLIANCE_LEVEL)
		else $error("compliance byte wrong");
	c_event: cover property (o_port_event);
	c_fault_clear: cover property (o_port_fault_hold[0] ##1 !o_port_fault_hold[0]);
	c_ident_read: cover property (i_reg_rd && i_page_sel == 3'h1);
endmodule

bind phy_port_status_pages phy_pages_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (
	.i_clk(i_clk), .i_srst(i_srst), .i_page_sel(i_page_sel),
	.i_port_sel(i_port_sel), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
	.i_port_resuming(i_port_resuming), .i_port_suspending(i_port_suspending),
	.o_port_disabled(o_port_disabled), .o_port_fault_hold(o_port_fault_hold),
	.o_port_event(o_port_event));

// File: bench/tb_top.sv
// Self-checking bench for the paged port status registers
`timescale 1ns/10ps
module tb_top;
	localparam logic [23:0] MAKER = 24'h3C_5A_96; // Arbitrary value
	localparam logic [23:0] PART = 24'h12_34_56; // Arbitrary value
	logic clk = 1'b0, srst = 1'b1, rvalid, ev;
	logic [2:0] pg, conn, bias, tchild, resm, susp, dis, fhold, ssp;
	logic [3:0] pt, ad;
	logic rd, wr;
	logic [7:0] wd, rdata, rnd = 8'h4B;
	logic [5:0] a_ls, b_ls;
	logic [8:0] spd;
	logic [63:0] id = {8'h01, 8'h00, MAKER, PART};
	int n_errors = 0, check_count = 0, n_ev = 0, ev0;
	always #2.5 clk = ~clk;
	llc_model llc (.i_clk(clk), .o_page_sel(pg), .o_port_sel(pt),
		.o_reg_addr(ad), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wd));
	phy_port_status_pages #(.NUM_PORTS(3), .CON_DEBOUNCE_CYC(20),
		.BIAS_DEBOUNCE_CYC(8), .MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
		.i_clk(clk), .i_srst(srst), .i_page_sel(pg), .i_port_sel(pt),
		.i_reg_addr(ad), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wd),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_a_pair_line_state(a_ls), .i_b_pair_line_state(b_ls),
		.i_conn_detect(conn), .i_bias_detect(bias), .i_tree_child(tchild),
		.i_peer_speed(spd), .i_port_resuming(resm),
		.i_port_suspending(susp), .i_port_suspended(ssp),
		.o_port_disabled(dis), .o_port_fault_hold(fhold),
		.o_port_event(ev));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (ev === 1'b1)
			n_ev++;
		if (rvalid === 1'b1 && llc.exp_q.size() == 0)
			check("stray read valid", 8'h01, 8'h00);
		else if (rvalid === 1'b1)
			check("read data", rdata, llc.exp_q.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		{a_ls, b_ls, conn, bias, resm, susp, spd, ssp} = '0;
		tchild = 3'h6;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check("disable", {5'h00, dis}, 8'h00);
		check("fault", {5'h00, fhold}, 8'h00);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			@(posedge clk);
			a_ls <= {rnd[5:2], k[1:0]};
			b_ls <= rnd[5:0];
			repeat (4) @(posedge clk);
			llc.acc(3'h0, 4'h0, 4'h8, 1'b1, {k[1:0], rnd[1:0], 4'h8});
			llc.acc(3'h0, 4'h1, 4'h8, 1'b1, {rnd[3:2], rnd[3:2], 4'h8});
		end
		@(posedge clk);
		a_ls <= 6'h27;
		b_ls <= 6'h1E;
		conn <= 3'h3;
		bias <= 3'h1;
		repeat (5) @(posedge clk);
		llc.acc(3'h0, 4'h0, 4'h8, 1'b1, 8'hE8);
		repeat (30) @(posedge clk);
		llc.acc(3'h0, 4'h0, 4'h8, 1'b1, 8'hE6);
		llc.acc(3'h0, 4'h1, 4'h8, 1'b1, 8'h7C);
		ssp <= 3'h1;
		llc.acc(3'h0, 4'h0, 4'h8, 1'b1, 8'hEE);
		ssp <= 3'h0;
		llc.acc(3'h0, 4'h0, 4'h8, 1'b0, 8'h01);
		llc.acc(3'h0, 4'h0, 4'h8, 1'b1, 8'hEF);
		llc.acc(3'h0, 4'h3, 4'h8, 1'b0, 8'h01);
		llc.acc(3'h1, 4'h1, 4'h8, 1'b0, 8'h01);
		check("disable", {5'h00, dis}, 8'h01);
		llc.acc(3'h0, 4'h3, 4'h8, 1'b1, 8'h00);
		llc.acc(3'h0, 4'h3, 4'h9, 1'b1, 8'h00);
		check("no event", {7'h00, n_ev != 0}, 8'h00);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			spd <= {6'h00, k[2:0]};
			repeat (2) @(posedge clk);
			llc.acc(3'h0, 4'h0, 4'h9, 1'b1,
				{(k > 2) ? 3'h2 : k[2:0], 5'h00});
		end
		llc.acc(3'h0, 4'h0, 4'h9, 1'b0, 8'h10);
		ev0 = n_ev;
		susp <= 3'h1;
		@(posedge clk);
		susp <= 3'h0;
		resm <= 3'h2;
		@(posedge clk);
		resm <= 3'h0;
		repeat (3) @(posedge clk);
		check("fault", {5'h00, fhold}, 8'h03);
		check("event", {7'h00, n_ev != ev0}, 8'h01);
		llc.acc(3'h0, 4'h0, 4'h9, 1'b1, 8'h58);
		llc.acc(3'h0, 4'h0, 4'h9, 1'b0, 8'h18);
		llc.acc(3'h0, 4'h0, 4'h9, 1'b1, 8'h50);
		check("fault", {5'h00, fhold}, 8'h02);
		for (int i = 0; i < 8; i++)
			llc.acc(3'h1, 4'h0, 4'h8 + i[3:0], 1'b1, id[63-8*i -: 8]);
		llc.acc(3'h0, 4'h0, 4'h3, 1'b1, 8'h00);
		llc.acc(3'h2, 4'h0, 4'h8, 1'b1, 8'h00);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check("reset", {2'h0, dis, fhold}, 8'h00);
		llc.acc(3'h0, 4'h0, 4'h8, 1'b1, 8'hE8);
		llc.acc(3'h0, 4'h0, 4'h9, 1'b1, 8'h40);
		repeat (3) @(posedge clk);
		check("reads left", 8'(llc.exp_q.size()), 8'h00);
		stop_test();
	end
endmodule

// File: pkg/filter_if.sv
// Link between the register bank and one stability filter
`timescale 1ns/10ps
interface filter_if;
	logic raw;
	logic stable;
	modport feed (output raw, input stable);
	modport filt (input raw, output stable);
endinterface

// File: pkg/phy_pages_pkg.sv
// Constants for the paged port-status and identification register bank
package phy_pages_pkg;
	// Page selection codes
	localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;
	localparam logic [2:0] PAGE_IDENT = 3'h1;
	localparam logic [2:0] PAGE_SEL_RST = 3'h0;
	// Register addresses, port status page
	localparam logic [3:0] ADDR_PORT_LINE_ROLE = 4'h8;
	localparam logic [3:0] ADDR_PORT_SPEED_EVENT = 4'h9;
	// Register addresses, identification page
	localparam logic [3:0] ADDR_COMPLIANCE = 4'h8;
	localparam logic [3:0] ADDR_IDENT_RSVD = 4'h9;
	localparam logic [3:0] ADDR_MAKER_B0 = 4'hA;
	localparam logic [3:0] ADDR_MAKER_B1 = 4'hB;
	localparam logic [3:0] ADDR_MAKER_B2 = 4'hC;
	localparam logic [3:0] ADDR_PART_B0 = 4'hD;
	localparam logic [3:0] ADDR_PART_B1 = 4'hE;
	localparam logic [3:0] ADDR_PART_B2 = 4'hF;
	// Field positions (bit 7 is the leftmost bit of a register)
	localparam int A_STATE_LSB = 6;
	localparam int B_STATE_LSB = 4;
	localparam int CHILD_BIT = 3;
	localparam int CON_BIT = 2;
	localparam int BIAS_BIT = 1;
	localparam int DIS_BIT = 0;
	localparam int PEER_SPEED_LSB = 5;
	localparam int EVENT_ENABLE_BIT = 4;
	localparam int FAULT_BIT = 3;
	// Line state codes
	localparam logic [1:0] LINE_Z = 2'h3;
	localparam logic [1:0] LINE_ONE = 2'h1;
	localparam logic [1:0] LINE_ZERO = 2'h2;
	localparam logic [1:0] LINE_INVALID = 2'h0;
	// Peer speed codes
	localparam logic [2:0] SPEED_S100 = 3'h0;
	localparam logic [2:0] SPEED_S200 = 3'h1;
	localparam logic [2:0] SPEED_S400 = 3'h2;
	// Fixed read values
	localparam logic [7:0] COMPLIANCE_LEVEL = 8'h01;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Reset values
	localparam logic DIS_RST = 1'b0;
	localparam logic EVENT_ENABLE_RST = 1'b0;
	localparam logic FAULT_RST = 1'b0;
	localparam logic CON_RST = 1'b0;
	localparam logic BIAS_RST = 1'b0;
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int CON_MIN_MS = 330;
	localparam int CON_DEBOUNCE_CYC =
		(CON_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BIAS_MIN_NS = 41600;
	localparam int BIAS_DEBOUNCE_CYC =
		(BIAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: src/phy_port_status_pages.sv
// Paged port status and identification registers of a three-port PHY
// How it works
// - A-pair line state reads 11 Z, 01 one, 10 zero, 00 invalid.
// - B-pair line state uses the same four codes as A-pair.
// - Child flag is 1 for child; disconnected, disabled, suspended ports read 1.
// - Connected flag rises only after connection is stable 330 to 350 ms.
// - Hardware reset clears connected flag; bus reset leaves it.
// - Bias flag rises only after incoming bias is stable about 41.6-52 us.
// - Port-disable bit disables its port; hardware reset clears it only.
// - Peer speed reads 000, 001, 010 for 100, 200, 400 Mbit/s.
// - Peer speed never reads above the 400 Mbit/s code.
// - With event enable set, a port change pulses the port event flag.
// - A resume or suspend fault sets the fault bit and holds port suspended.
// - Resume fault: no incoming bias; suspend fault: bias still present.
// - Writing 1 clears the fault bit; hardware reset clears it too.
// - Page selection picks the page for addresses 8 to 15.
// - Unimplemented selected port makes the whole status page read zero.
// - Maker code sits most significant byte first from address 1010b.
`timescale 1ns/10ps
module phy_port_status_pages #(
	parameter int NUM_PORTS = 3,
	parameter int CON_DEBOUNCE_CYC = phy_pages_pkg::CON_DEBOUNCE_CYC,
	parameter int BIAS_DEBOUNCE_CYC = phy_pages_pkg::BIAS_DEBOUNCE_CYC,
	// Arbitrary neutral identification values
	parameter logic [23:0] MAKER_CODE = 24'h5A_A5_01,
	parameter logic [23:0] PART_CODE = 24'h00_00_01
) (
	input wire logic i_clk, // System clock, 200 MHz
	input wire logic i_srst, // Hardware reset, synchronous, active high
	input wire logic [2:0] i_page_sel, // Page selection field
	input wire logic [3:0] i_port_sel, // Port selection field
	input wire logic [3:0] i_reg_addr, // Register address
	input wire logic i_reg_rd, // Register read strobe
	input wire logic i_reg_wr, // Register write strobe
	input wire logic [7:0] i_reg_wdata, // Register write data
	output logic [7:0] o_reg_rdata, // Read data, held until next read
	output logic o_reg_rvalid, // Read data valid pulse
	input wire logic [2*NUM_PORTS-1:0] i_a_pair_line_state, // A-pair pins
	input wire logic [2*NUM_PORTS-1:0] i_b_pair_line_state, // B-pair pins
	input wire logic [NUM_PORTS-1:0] i_conn_detect, // Raw connection pins
	input wire logic [NUM_PORTS-1:0] i_bias_detect, // Raw bias pins
	input wire logic [NUM_PORTS-1:0] i_tree_child, // Child role from tree ID
	input wire logic [3*NUM_PORTS-1:0] i_peer_speed, // Peer speed per port
	input wire logic [NUM_PORTS-1:0] i_port_resuming, // Port in resume check
	input wire logic [NUM_PORTS-1:0] i_port_suspending, // Port in suspend
	input wire logic [NUM_PORTS-1:0] i_port_suspended, // Port suspended
	output logic [NUM_PORTS-1:0] o_port_disabled, // Port disable control
	output logic [NUM_PORTS-1:0] o_port_fault_hold, // Fault: hold suspended
	output logic o_port_event // Port event flag set pulse
);
	localparam int NP = NUM_PORTS;

	generate
		if (NP < 1 || NP > 16) begin : g_bad
			$error("NUM_PORTS must lie between 1 and 16");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Address hit on the status page for a given port and register
	function automatic logic status_hit(input logic [2:0] page,
		input logic [3:0] psel, input logic [3:0] addr,
		input logic [3:0] port, input logic [3:0] reg_addr);
		status_hit = (page == phy_pages_pkg::PAGE_PORT_STATUS) &&
			(psel == port) && (addr == reg_addr);
	endfunction

	// Peer speed clamped to the highest reportable code
	function automatic logic [2:0] clamp_speed(input logic [2:0] speed);
		if (speed > phy_pages_pkg::SPEED_S400) begin
			clamp_speed = phy_pages_pkg::SPEED_S400;
		end else begin
			clamp_speed = speed;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-port state

	logic [1:0] a_sync1 [NP];
	logic [1:0] a_sync2 [NP];
	logic [1:0] b_sync1 [NP];
	logic [1:0] b_sync2 [NP];
	logic [NP-1:0] conn_sync1;
	logic [NP-1:0] conn_sync2;
	logic [NP-1:0] bias_sync1;
	logic [NP-1:0] bias_sync2;
	logic [NP-1:0] con_flag;
	logic [NP-1:0] bias_flag;
	logic [NP-1:0] child_flag;
	logic [2:0] speed_flag [NP];
	logic [NP-1:0] dis_reg;
	logic [NP-1:0] port_event_enable_reg;
	logic [NP-1:0] fault_reg;
	logic [NP-1:0] fault_set;
	logic [NP-1:0] fault_clr;
	logic [NP-1:0] watch_prev_reg;
	logic [NP-1:0] port_changed;
	logic [3:0] watch_now [NP];
	logic [3:0] watch_old_reg [NP];

	filter_if con_if [NP] ();
	filter_if bias_if [NP] ();

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			// Two-stage synchronisers for everything arriving from pins
			always_ff @(posedge i_clk) begin
				a_sync1[p] <= i_a_pair_line_state[2*p +: 2];
				a_sync2[p] <= a_sync1[p];
				b_sync1[p] <= i_b_pair_line_state[2*p +: 2];
				b_sync2[p] <= b_sync1[p];
			end

			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					conn_sync1[p] <= phy_pages_pkg::CON_RST;
					conn_sync2[p] <= phy_pages_pkg::CON_RST;
					bias_sync1[p] <= phy_pages_pkg::BIAS_RST;
					bias_sync2[p] <= phy_pages_pkg::BIAS_RST;
				end else begin
					conn_sync1[p] <= i_conn_detect[p];
					conn_sync2[p] <= conn_sync1[p];
					bias_sync1[p] <= i_bias_detect[p];
					bias_sync2[p] <= bias_sync1[p];
				end
			end

			// Connection debounce, cleared by hardware reset or by any drop of the connection
			assign con_if[p].raw = conn_sync2[p];
			stable_filter #(
				.CYCLES(CON_DEBOUNCE_CYC)
			) u_con_filter (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.port(con_if[p])
			);
			assign con_flag[p] = con_if[p].stable;

			// Incoming bias debounce
			assign bias_if[p].raw = bias_sync2[p];
			stable_filter #(
				.CYCLES(BIAS_DEBOUNCE_CYC)
			) u_bias_filter (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.port(bias_if[p])
			);
			assign bias_flag[p] = bias_if[p].stable;

			// Inactive ports always report as children
			assign child_flag[p] = i_tree_child[p] || !con_flag[p] ||
				dis_reg[p] || i_port_suspended[p] || fault_reg[p];

			assign speed_flag[p] = clamp_speed(i_peer_speed[3*p +: 3]);

			// Port disable control
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					dis_reg[p] <= phy_pages_pkg::DIS_RST;
				end else if (i_reg_wr && status_hit(i_page_sel, i_port_sel,
					i_reg_addr, 4'(p),
					phy_pages_pkg::ADDR_PORT_LINE_ROLE)) begin
					dis_reg[p] <= i_reg_wdata[phy_pages_pkg::DIS_BIT];
				end
			end

			// Port event enable
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					port_event_enable_reg[p] <=
						phy_pages_pkg::EVENT_ENABLE_RST;
				end else if (i_reg_wr && status_hit(i_page_sel, i_port_sel,
					i_reg_addr, 4'(p),
					phy_pages_pkg::ADDR_PORT_SPEED_EVENT)) begin
					port_event_enable_reg[p] <=
						i_reg_wdata[phy_pages_pkg::EVENT_ENABLE_BIT];
				end
			end

			// Fault: a new fault outranks a clearing write
			assign fault_set[p] =
				(i_port_resuming[p] && !bias_flag[p]) ||
				(i_port_suspending[p] && bias_flag[p]);
			assign fault_clr[p] = i_reg_wr &&
				i_reg_wdata[phy_pages_pkg::FAULT_BIT] &&
				status_hit(i_page_sel, i_port_sel, i_reg_addr, 4'(p),
				phy_pages_pkg::ADDR_PORT_SPEED_EVENT);

			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					fault_reg[p] <= phy_pages_pkg::FAULT_RST;
				end else if (fault_set[p]) begin
					fault_reg[p] <= 1'b1;
				end else if (fault_clr[p]) begin
					fault_reg[p] <= 1'b0;
				end
			end

			// Change watch on connected, bias, disabled and fault bits
			assign watch_now[p] = {con_flag[p], bias_flag[p], dis_reg[p],
				fault_reg[p]};

			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					watch_old_reg[p] <= '0;
					watch_prev_reg[p] <= 1'b0;
				end else begin
					watch_old_reg[p] <= watch_now[p];
					watch_prev_reg[p] <= 1'b1;
				end
			end

			assign port_changed[p] = watch_prev_reg[p] &&
				port_event_enable_reg[p] &&
				(watch_now[p] != watch_old_reg[p]);
		end
	endgenerate

	assign o_port_disabled = dis_reg;
	assign o_port_fault_hold = fault_reg;

	////////////////////////////////////////////////////////////////////////
	// Port event notification

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_port_event <= 1'b0;
		end else begin
			o_port_event <= |port_changed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [7:0] line_role_sel;
	logic [7:0] speed_event_sel;
	logic port_valid;
	logic [7:0] rd_next;

	// Gather the fields of whichever port is selected right now
	always_comb begin
		line_role_sel = phy_pages_pkg::READ_ZERO;
		speed_event_sel = phy_pages_pkg::READ_ZERO;
		port_valid = 1'b0;
		for (int i = 0; i < NP; i++) begin
			if (i_port_sel == 4'(i)) begin
				port_valid = 1'b1;
				line_role_sel[phy_pages_pkg::A_STATE_LSB +: 2] =
					a_sync2[i];
				line_role_sel[phy_pages_pkg::B_STATE_LSB +: 2] =
					b_sync2[i];
				line_role_sel[phy_pages_pkg::CHILD_BIT] = child_flag[i];
				line_role_sel[phy_pages_pkg::CON_BIT] = con_flag[i];
				line_role_sel[phy_pages_pkg::BIAS_BIT] = bias_flag[i];
				line_role_sel[phy_pages_pkg::DIS_BIT] = dis_reg[i];
				speed_event_sel[phy_pages_pkg::PEER_SPEED_LSB +: 3] =
					speed_flag[i];
				speed_event_sel[phy_pages_pkg::EVENT_ENABLE_BIT] =
					port_event_enable_reg[i];
				speed_event_sel[phy_pages_pkg::FAULT_BIT] = fault_reg[i];
			end
		end
	end

	// Page decode for addresses 8 to 15
	always_comb begin
		rd_next = phy_pages_pkg::READ_ZERO;
		if (i_page_sel == phy_pages_pkg::PAGE_PORT_STATUS) begin
			if (port_valid) begin
				case (i_reg_addr)
					phy_pages_pkg::ADDR_PORT_LINE_ROLE: begin
						rd_next = line_role_sel;
					end
					phy_pages_pkg::ADDR_PORT_SPEED_EVENT: begin
						rd_next = speed_event_sel;
					end
					default: begin
						rd_next = phy_pages_pkg::READ_ZERO;
					end
				endcase
			end
		end else if (i_page_sel == phy_pages_pkg::PAGE_IDENT) begin
			case (i_reg_addr)
				phy_pages_pkg::ADDR_COMPLIANCE: begin
					rd_next = phy_pages_pkg::COMPLIANCE_LEVEL;
				end
				phy_pages_pkg::ADDR_MAKER_B0: begin
					rd_next = MAKER_CODE[23:16];
				end
				phy_pages_pkg::ADDR_MAKER_B1: begin
					rd_next = MAKER_CODE[15:8];
				end
				phy_pages_pkg::ADDR_MAKER_B2: begin
					rd_next = MAKER_CODE[7:0];
				end
				phy_pages_pkg::ADDR_PART_B0: begin
					rd_next = PART_CODE[23:16];
				end
				phy_pages_pkg::ADDR_PART_B1: begin
					rd_next = PART_CODE[15:8];
				end
				phy_pages_pkg::ADDR_PART_B2: begin
					rd_next = PART_CODE[7:0];
				end
				default: begin
					rd_next = phy_pages_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// Read data is captured on the strobe and held until the next read
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_reg_rdata <= phy_pages_pkg::READ_ZERO;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rd_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end
endmodule

// File: src/stable_filter.sv
// Level filter: output rises only after the input has held high long enough
`timescale 1ns/10ps
module stable_filter #(
	parameter int CYCLES = 8
) (
	input wire logic i_clk, // System clock
	input wire logic i_srst, // Hardware reset, synchronous
	filter_if.filt port // Raw level in, filtered level out
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(CYCLES);

	logic [CW-1:0] cnt_reg;

	generate
		if (CYCLES < 1) begin : g_bad
			$error("stable_filter needs CYCLES of at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Any drop restarts the wait; the count saturates at its end
	always_ff @(posedge i_clk) begin
		if (i_srst || !port.raw) begin
			cnt_reg <= '0;
		end else if (cnt_reg != CNT_MAX) begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			port.stable <= 1'b0;
		end else begin
			port.stable <= port.raw && (cnt_reg == CNT_MAX);
		end
	end
endmodule
